// ===== inc/usp_pkg.sv
// Purpose: shared constants and types for the serial channel with handshake
// Assumes: 32-bit register port, byte-wide characters
// Notes:   offsets are byte addresses of word registers
package usp_pkg;

  // register offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_DIVIDE = 8'h10;
  localparam logic [7:0] OFF_RTSLVL = 8'h14;

  // control field positions
  localparam int CTRL_TXEN    = 0;
  localparam int CTRL_RXEN    = 1;
  localparam int CTRL_LOOP    = 2;
  localparam int CTRL_RTSAUTO = 3;
  localparam int CTRL_RTSON   = 4;
  localparam int CTRL_STOP    = 5;

  // reset values
  localparam logic [15:0] DIV_RST    = 16'h001b;
  localparam logic [3:0]  RTSLVL_RST = 4'h6;

  localparam int DATA_BITS = 8;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_DATA = 3'b010,
    TX_STOP = 3'b100
  } usp_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_DATA = 3'b010,
    RX_STOP = 3'b100
  } usp_rx_state_t;

  typedef struct packed {
    logic txEn;
    logic rxEn;
    logic loop;
    logic rtsAuto;
    logic rtsOn;
  } usp_ctrl_t;

  // register-port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } usp_bus_req_t;

endpackage

// ===== logic/usp_uart.sv
// Purpose: one asynchronous serial channel with clear/request-to-send
// Assumes: bit clock from an internal divider only; pins are asynchronous
// Notes:   receive queue depth is a parameter; RXDATA read pops the queue
`timescale 1ns/1ps
module usp_uart
  import usp_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  // system
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // serial pins
  output logic             ser0TxLine,
  input  wire logic        ser0RxLine,
  input  wire logic        ser0ClearToSendN,
  output logic             ser0RequestToSendN
);

  localparam int PW = $clog2(QDEPTH);

  typedef struct packed {
    usp_ctrl_t                     ctrl;
    logic                          stopped;
    logic [15:0]                   divide;
    logic [15:0]                   divCnt;
    logic                          sclk;
    logic [3:0]                    rtsLvl;
    usp_tx_state_t                 txState;
    logic [7:0]                    txShift;
    logic [2:0]                    txBit;
    logic [7:0]                    txHold;
    logic                          txFull;
    logic                          txSer;
    logic                          txPin;
    usp_rx_state_t                 rxState;
    logic [7:0]                    rxShift;
    logic [2:0]                    rxBit;
    logic                          rxPrev;
    logic                          overrun;
    logic                          frameErr;
    logic [QDEPTH-1:0][7:0]        queue;
    logic [PW-1:0]                 wrPtr;
    logic [PW-1:0]                 rdPtr;
    logic [PW:0]                   count;
    logic [31:0]                   rdData;
    logic                          rtsN;
    logic                          rxS1;
    logic                          rxS2;
    logic                          rxLast;
    logic                          ctsS1;
    logic                          ctsS2;
  } usp_state_t;

  usp_state_t   s_r;
  usp_state_t   s_nxt;
  usp_bus_req_t req;
  logic         riseEn;
  logic         fallEn;
  logic         rxIn;
  logic         ctsOk;
  logic         wake;
  logic         popEn;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  function automatic logic hit(input usp_bus_req_t r, input logic [7:0] o);
    return r.addr == o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // serial clock: internal divider is the only bit-rate source
  assign riseEn = !s_r.stopped && (s_r.divCnt == 16'h0000) && !s_r.sclk;
  assign fallEn = !s_r.stopped && (s_r.divCnt == 16'h0000) && s_r.sclk;
  // loopback feeds the receiver from the shifter, not the pin
  assign rxIn   = s_r.ctrl.loop ? s_r.txSer : s_r.rxS2;
  assign ctsOk  = !s_r.ctsS2;
  assign wake   = s_r.stopped && (s_r.rxS2 != s_r.rxLast);
  assign popEn  = req.rd && hit(req, OFF_RXDATA) && (s_r.count != '0);

  always_comb begin
    s_nxt = s_r;
    s_nxt.rxS1   = ser0RxLine;
    s_nxt.rxS2   = s_r.rxS1;
    s_nxt.rxLast = s_r.rxS2;
    s_nxt.ctsS1  = ser0ClearToSendN;
    s_nxt.ctsS2  = s_r.ctsS1;

    if (!s_r.stopped) begin
      if (s_r.divCnt == 16'h0000) begin
        s_nxt.divCnt = s_r.divide - 16'h0001;
        s_nxt.sclk   = !s_r.sclk;
      end else begin
        s_nxt.divCnt = s_r.divCnt - 16'h0001;
      end
    end
    if (wake)
      s_nxt.stopped = 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // transmitter, changes only on serial clock fall
    if (fallEn) begin
      case (s_r.txState)
        TX_IDLE: begin
          s_nxt.txSer = 1'b1;
          if (s_r.ctrl.txEn && s_r.txFull && ctsOk) begin
            s_nxt.txSer   = 1'b0;
            s_nxt.txShift = s_r.txHold;
            s_nxt.txFull  = 1'b0;
            s_nxt.txBit   = 3'h0;
            s_nxt.txState = TX_DATA;
          end
        end
        TX_DATA: begin
          s_nxt.txSer   = s_r.txShift[0];
          s_nxt.txShift = {1'b0, s_r.txShift[7:1]};
          s_nxt.txBit   = s_r.txBit + 3'h1;
          if (s_r.txBit == 3'(DATA_BITS - 1))
            s_nxt.txState = TX_STOP;
        end
        TX_STOP: begin
          s_nxt.txSer   = 1'b1;
          s_nxt.txState = TX_IDLE;
        end
        default: begin
          s_nxt.txSer   = 1'b1;
          s_nxt.txState = TX_IDLE;
        end
      endcase
    end
    s_nxt.txPin = (s_r.ctrl.loop || !s_r.ctrl.txEn) ? 1'b1 : s_r.txSer;

    //////////////////////////////////////////////////////////////////////////
    // receiver, samples only on serial clock rise
    if (popEn) begin
      s_nxt.rdPtr = s_r.rdPtr + PW'(1);
      s_nxt.count = s_r.count - (PW+1)'(1);
    end
    // clear ahead of the receiver so a same-cycle error set wins
    if (req.rd && hit(req, OFF_STATUS))
      {s_nxt.overrun, s_nxt.frameErr} = 2'b00;
    if (riseEn) begin
      s_nxt.rxPrev = rxIn;
      case (s_r.rxState)
        RX_IDLE: begin
          if (s_r.ctrl.rxEn && s_r.rxPrev && !rxIn) begin
            s_nxt.rxBit   = 3'h0;
            s_nxt.rxState = RX_DATA;
          end
        end
        RX_DATA: begin
          s_nxt.rxShift = {rxIn, s_r.rxShift[7:1]};
          s_nxt.rxBit   = s_r.rxBit + 3'h1;
          if (s_r.rxBit == 3'(DATA_BITS - 1))
            s_nxt.rxState = RX_STOP;
        end
        RX_STOP: begin
          s_nxt.rxState = RX_IDLE;
          if (!rxIn) begin
            s_nxt.frameErr = 1'b1;
          end else if (s_r.count == (PW+1)'(QDEPTH) && !popEn) begin
            s_nxt.overrun = 1'b1;
          end else begin
            s_nxt.queue[s_r.wrPtr] = s_r.rxShift;
            s_nxt.wrPtr = s_r.wrPtr + PW'(1);
            s_nxt.count = s_nxt.count + (PW+1)'(1);
          end
        end
        default: s_nxt.rxState = RX_IDLE;
      endcase
    end

    // request-to-send: fill level or software level
    if (s_r.ctrl.rtsAuto)
      s_nxt.rtsN = (s_r.count >= (PW+1)'(s_r.rtsLvl));
    else
      s_nxt.rtsN = !s_r.ctrl.rtsOn;

    //////////////////////////////////////////////////////////////////////////
    // register port; sticky errors clear on status read, a new set wins
    s_nxt.rdData = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        OFF_CTRL:   s_nxt.rdData = {26'h0, s_r.stopped, s_r.ctrl.rtsOn,
                                    s_r.ctrl.rtsAuto, s_r.ctrl.loop,
                                    s_r.ctrl.rxEn, s_r.ctrl.txEn};
        OFF_STATUS: s_nxt.rdData = {20'h0, 4'(s_r.count), 1'b0,
                                    s_r.stopped, ctsOk, s_r.frameErr,
                                    s_r.overrun, s_r.count != '0,
                                    s_r.txState != TX_IDLE, s_r.txFull};
        OFF_RXDATA: s_nxt.rdData = {24'h0, s_r.queue[s_r.rdPtr]};
        OFF_DIVIDE: s_nxt.rdData = {16'h0, s_r.divide};
        OFF_RTSLVL: s_nxt.rdData = {28'h0, s_r.rtsLvl};
        default:    s_nxt.rdData = 32'h0000_0000;
      endcase
    end
    if (req.wr) begin
      case (req.addr)
        OFF_CTRL: begin
          s_nxt.ctrl.txEn    = req.wdata[CTRL_TXEN];
          s_nxt.ctrl.rxEn    = req.wdata[CTRL_RXEN];
          s_nxt.ctrl.loop    = req.wdata[CTRL_LOOP];
          s_nxt.ctrl.rtsAuto = req.wdata[CTRL_RTSAUTO];
          s_nxt.ctrl.rtsOn   = req.wdata[CTRL_RTSON];
          if (req.wdata[CTRL_STOP] && !wake)
            s_nxt.stopped = 1'b1;
        end
        // refused while the holding register is occupied
        OFF_TXDATA: if (!s_r.txFull) begin
          s_nxt.txHold = req.wdata[7:0];
          s_nxt.txFull = 1'b1;
        end
        // zero divisor would wrap the reload to the slowest bit rate, so clamp to one
        OFF_DIVIDE: s_nxt.divide = (req.wdata[15:0] == 16'h0) ? 16'h0001
                                                              : req.wdata[15:0];
        OFF_RTSLVL: s_nxt.rtsLvl = req.wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_r         <= '0;
      s_r.divide  <= DIV_RST;
      s_r.rtsLvl  <= RTSLVL_RST;
      s_r.txState <= TX_IDLE;
      s_r.rxState <= RX_IDLE;
      s_r.txSer   <= 1'b1;
      s_r.txPin   <= 1'b1;
      s_r.rtsN    <= 1'b1;
      s_r.rxPrev  <= 1'b1;
      s_r.rxS1    <= 1'b1;
      s_r.rxS2    <= 1'b1;
      s_r.rxLast  <= 1'b1;
      s_r.ctsS1   <= 1'b1;
      s_r.ctsS2   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdata           = s_r.rdData;
  assign ser0TxLine         = s_r.txPin;
  assign ser0RequestToSendN = s_r.rtsN;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  tx_mark_a: assert property (
    (s_r.ctrl.loop || !s_r.ctrl.txEn) |=> s_r.txPin)
    else $error("transmit line not held at mark");
  tx_fall_a: assert property (
    $changed(s_r.txSer) |-> $past(fallEn))
    else $error("transmit bit changed off the falling edge");
  tx_lsb_a: assert property (
    (fallEn && s_r.txState == TX_DATA) |=> s_r.txSer == $past(s_r.txShift[0]))
    else $error("transmit bit order wrong");
  rx_rise_a: assert property (
    $changed(s_r.rxShift) |-> $past(riseEn))
    else $error("receive sample off the rising edge");
  rx_lsb_a: assert property (
    (riseEn && s_r.rxState == RX_DATA) |=> s_r.rxShift[7] == $past(rxIn))
    else $error("receive bit order wrong");
  clk_wake_a: assert property (
    wake |=> !s_r.stopped ##1 !s_r.stopped || $past(req.wr, 1))
    else $error("receive transition did not restart clock");
  cts_gate_a: assert property (
    (fallEn && s_r.txState == TX_IDLE && !ctsOk) |=> s_r.txState == TX_IDLE)
    else $error("character started without clear-to-send");
  rts_level_a: assert property (
    (s_r.ctrl.rtsAuto && s_r.count >= (PW+1)'(s_r.rtsLvl)) |=> s_r.rtsN)
    else $error("request-to-send not negated at fill level");
  div_hold_a: assert property (
    (s_r.stopped && !wake) |=> $stable(s_r.divCnt) && !riseEn && !fallEn)
    else $error("bit clock ran while stopped");
  tx_start_a: assert property (
    (fallEn && s_r.txState == TX_IDLE && s_r.ctrl.txEn && s_r.txFull && ctsOk)
    |=> !s_r.txSer ##1 s_r.txState == TX_DATA)
    else $error("start bit missing");

endmodule

// ===== verif/usp_remote_model.sv
// Purpose: remote serial device facing one serial channel
// Assumes: bit time of BIT_CYC system clocks, matching the divider setting
// Notes:   receive line rests high between frames, like a pulled-up mark
`timescale 1ns/1ps
module usp_remote_model #(
  parameter int BIT_CYC = 8
) (
  // clock
  input  wire logic       clk_sys,
  // serial side
  input  wire logic       txLine,
  output logic            rxLine,
  output logic            clearToSendN,
  // bench side
  input  wire logic       holdOff,
  output logic            gotChar,
  output logic [7:0]      gotByte,
  output logic            gotFrameOk
);
  // permission is withdrawn only when the bench asks for it
  assign clearToSendN = holdOff;

  initial begin
    rxLine     = 1'b1;
    gotChar    = 1'b0;
    gotByte    = 8'h00;
    gotFrameOk = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // each bit held a whole bit time, so one rise sample lands in it
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      rxLine <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clk_sys);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // mid-bit sampling from the start edge; stop must read high
  initial begin
    forever begin
      @(negedge txLine);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      gotFrameOk = !txLine;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        gotByte[i] = txLine;
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      gotFrameOk = gotFrameOk & txLine;
      gotChar <= 1'b1;
      @(posedge clk_sys);
      gotChar <= 1'b0;
    end
  end
endmodule

// ===== verif/uart_serial_pins_with_handshake_tb_top.sv
// Purpose: self-checking bench for one serial channel with handshake
// Assumes: divider set to 4, so a bit lasts 8 system clocks
// Notes:   reads and sent characters are checked from expectation queues
`timescale 1ns/1ps
module uart_serial_pins_with_handshake_tb_top;
  import usp_pkg::*;
  logic        clk_sys, reset_n, regWr, regRd, rdSeen;
  logic [7:0]  regAddr, b;
  logic [31:0] regWdata, regRdata;
  logic        txLine, rxLine, ctsN, rtsN, holdOff, gotChar, gotFrameOk;
  logic [7:0]  gotByte;
  logic [7:0]  rb [2];
  logic [31:0] expRd [$];
  logic [31:0] expTx [$];
  int          n_fail, n_checks, seed, hi;

  usp_uart dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .ser0TxLine(txLine), .ser0RxLine(rxLine), .ser0ClearToSendN(ctsN),
    .ser0RequestToSendN(rtsN));
  usp_remote_model #(.BIT_CYC(8)) rem (.clk_sys(clk_sys), .txLine(txLine),
    .rxLine(rxLine), .clearToSendN(ctsN), .holdOff(holdOff),
    .gotChar(gotChar), .gotByte(gotByte), .gotFrameOk(gotFrameOk));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expRd.push_back(e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wait_tx();
    for (int k = 0; k < 400 && expTx.size() != 0; k++) @(posedge clk_sys);
    check("txDrained", expTx.size(), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (rdSeen)
      check("regRdata", regRdata, expRd.pop_front());
    if (gotChar) begin
      check("txChar", {24'h0, gotByte}, expTx.pop_front());
      check("txFrame", {31'h0, gotFrameOk}, 32'h1);
    end
    rdSeen <= regRd;
  end

  // whole run is under 1000 cycles; five times that means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_fail++;
    give_verdict();
  end

  initial begin
    seed     = 32'h0bff9ee5;
    reset_n  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    regWr    = 1'b0;
    regRd    = 1'b0;
    holdOff  = 1'b0;
    rdSeen   = 1'b0;
    n_fail   = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    check("txIdle", {31'h0, txLine}, 32'h1);
    check("rtsIdle", {31'h0, rtsN}, 32'h1);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_DIVIDE, {16'h0, DIV_RST});
    rd(OFF_RTSLVL, {28'h0, RTSLVL_RST});
    rd(8'h18, 32'h0);
    $display("test reset done");
    wr(OFF_DIVIDE, 32'h4);
    wr(OFF_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) begin
      b = 8'($random(seed));
      expTx.push_back({24'h0, b});
      wr(OFF_TXDATA, {24'h0, b});
      wait_tx();
    end
    check("txRest", {31'h0, txLine}, 32'h1);
    $display("test transmit done");
    holdOff <= 1'b1;
    repeat (4) @(posedge clk_sys);
    expTx.push_back(32'h5a);
    wr(OFF_TXDATA, 32'h5a);
    hi = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      hi += int'(txLine === 1'b1);
    end
    check("txHeld", hi, 32'd40);
    holdOff <= 1'b0;
    wait_tx();
    $display("test clear to send done");
    wr(OFF_RTSLVL, 32'h2);
    wr(OFF_CTRL, 32'h13);
    @(posedge clk_sys);
    check("rtsManual", {31'h0, rtsN}, 32'h0);
    wr(OFF_CTRL, 32'hb);
    @(posedge clk_sys);
    check("rtsLow", {31'h0, rtsN}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      rb[i] = 8'($random(seed));
      rem.send_byte(rb[i]);
    end
    repeat (16) @(posedge clk_sys);
    check("rtsLevel", {31'h0, rtsN}, 32'h1);
    // two queued, clear-to-send granted, no errors, nothing to send
    rd(OFF_STATUS, 32'h0000_0224);
    rd(OFF_RXDATA, {24'h0, rb[0]});
    rd(OFF_RXDATA, {24'h0, rb[1]});
    repeat (2) @(posedge clk_sys);
    check("rtsDrained", {31'h0, rtsN}, 32'h0);
    $display("test receive done");
    wr(OFF_CTRL, 32'h7);
    wr(OFF_TXDATA, 32'hc3);
    hi = 0;
    for (int k = 0; k < 120; k++) begin
      @(posedge clk_sys);
      hi += int'(txLine === 1'b1);
    end
    check("loopPin", hi, 32'd120);
    rd(OFF_RXDATA, 32'hc3);
    $display("test loopback done");
    wr(OFF_CTRL, 32'h23);
    rd(OFF_CTRL, 32'h23);
    rem.send_byte(8'hff);
    repeat (16) @(posedge clk_sys);
    rd(OFF_CTRL, 32'h3);
    $display("test wake done");
    give_verdict();
  end
endmodule
